// ==== design/bmx_consts.svh ====
// Shared constants of the six by six bus matrix: sizes, address map, connectivity
`ifndef BMX_CONSTS_SVH
`define BMX_CONSTS_SVH

// Port counts and field widths
`define BMX_NUM_MASTERS 6
`define BMX_NUM_SLAVES  6
`define BMX_ADDR_W      32
`define BMX_DATA_W      32
`define BMX_ID_W        3
`define BMX_STRB_W      4

// Master indices
`define BMX_M_GP_DMA    3'h0
`define BMX_M_USB_DMA   3'h1
`define BMX_M_LCD_DMA   3'h2
`define BMX_M_PERIPH_DMA 3'h3
`define BMX_M_CPU_INSTR 3'h4
`define BMX_M_CPU_DATA  3'h5

// Slave indices
`define BMX_S_ROM       3'h0
`define BMX_S_SRAM      3'h1
`define BMX_S_LCD_UI    3'h2
`define BMX_S_USB_RAM   3'h3
`define BMX_S_EXT_MEM   3'h4
`define BMX_S_PERIPH    3'h5

// Address map, inclusive low and high bounds, same for every master
`define BMX_ROM_LO      32'h0040_0000
`define BMX_ROM_HI      32'h004F_FFFF
`define BMX_SRAM_LO     32'h0030_0000
`define BMX_SRAM_HI     32'h003F_FFFF
`define BMX_LCD_UI_LO   32'h0050_0000
`define BMX_LCD_UI_HI   32'h005F_FFFF
`define BMX_USB_RAM_LO  32'h0060_0000
`define BMX_USB_RAM_HI  32'h006F_FFFF
`define BMX_EXT_MEM_LO  32'h1000_0000
`define BMX_EXT_MEM_HI  32'h8FFF_FFFF
`define BMX_PERIPH_LO   32'hF000_0000
`define BMX_PERIPH_HI   32'hFFFF_FFFF

// Per slave, the masters wired to it, bit m set for master m
`define BMX_CONN_ROM     6'h3B
`define BMX_CONN_SRAM    6'h3F
`define BMX_CONN_LCD_UI  6'h30
`define BMX_CONN_USB_RAM 6'h30
`define BMX_CONN_EXT_MEM 6'h3F
`define BMX_CONN_PERIPH  6'h07

`endif

// ==== design/bmx_pkg.sv ====
// Types shared by the bus matrix modules
`include "bmx_consts.svh"
package bmx_pkg;

  // Transfer size on the address and data buses
  typedef enum logic [1:0] {
    BMX_SIZE_BYTE = 2'h0,
    BMX_SIZE_HALF = 2'h1,
    BMX_SIZE_WORD = 2'h2
  } bmx_size_e;

  // Request held by a master until its answer
  typedef struct packed {
    logic                   valid;
    logic [`BMX_ADDR_W-1:0] addr;
    logic                   write;
    logic [1:0]             size;
    logic [`BMX_DATA_W-1:0] wdata;
  } bmx_mreq_s;

  // Answer to a master, done is a one-cycle pulse
  typedef struct packed {
    logic                   done;
    logic                   err;
    logic [`BMX_DATA_W-1:0] rdata;
  } bmx_mrsp_s;

  // Request presented to a slave
  typedef struct packed {
    logic                   valid;
    logic [`BMX_ADDR_W-1:0] addr;
    logic                   write;
    logic [1:0]             size;
    logic [`BMX_STRB_W-1:0] strb;
    logic [`BMX_DATA_W-1:0] wdata;
    logic [`BMX_ID_W-1:0]   master;
  } bmx_sreq_s;

  // Answer from a slave
  typedef struct packed {
    logic                   ready;
    logic                   err;
    logic [`BMX_DATA_W-1:0] rdata;
  } bmx_srsp_s;

endpackage

// ==== design/bmx_addr_decoder.sv ====
// Address decoder of one master port, shared address map
`timescale 1ns/1ps
`default_nettype none
`include "bmx_consts.svh"
module bmx_addr_decoder #(
  parameter int NUM_SLAVES = `BMX_NUM_SLAVES
) (
  input  wire logic [`BMX_ADDR_W-1:0] i_addr,
  output logic                        o_hit,
  output logic [`BMX_ID_W-1:0]        o_slave
);
  import bmx_pkg::*;

  // Identical table in every instance, so all masters see one map
  localparam logic [`BMX_ADDR_W-1:0] LO [NUM_SLAVES] = '{`BMX_ROM_LO, `BMX_SRAM_LO, `BMX_LCD_UI_LO,
                                                         `BMX_USB_RAM_LO, `BMX_EXT_MEM_LO, `BMX_PERIPH_LO};
  localparam logic [`BMX_ADDR_W-1:0] HI [NUM_SLAVES] = '{`BMX_ROM_HI, `BMX_SRAM_HI, `BMX_LCD_UI_HI,
                                                         `BMX_USB_RAM_HI, `BMX_EXT_MEM_HI, `BMX_PERIPH_HI};

  // First matching window wins; windows do not overlap
  always_comb begin
    o_hit   = 1'b0;
    o_slave = '0;
    for (int s = 0; s < NUM_SLAVES; s++) begin
      if (!o_hit && i_addr >= LO[s] && i_addr <= HI[s]) begin
        o_hit   = 1'b1;
        o_slave = `BMX_ID_W'(s);
      end
    end
  end
endmodule // bmx_addr_decoder
`default_nettype wire

// ==== design/bmx_slave_arbiter.sv ====
// Arbiter of one slave port, fixed priority or round robin
`timescale 1ns/1ps
`default_nettype none
`include "bmx_consts.svh"
module bmx_slave_arbiter #(
  parameter int NUM_MASTERS = `BMX_NUM_MASTERS
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_en,
  input  wire logic                   i_round_robin,
  input  wire logic [NUM_MASTERS-1:0] i_req,
  output logic      [NUM_MASTERS-1:0] o_grant
);
  import bmx_pkg::*;

  logic [`BMX_ID_W-1:0]   last;
  logic [NUM_MASTERS-1:0] next_grant;
  logic [`BMX_ID_W-1:0]   next_last;
  logic                   found;
  int                     idx;

  // Round robin starts after the last winner; fixed favours index 0
  always_comb begin
    next_grant = '0;
    next_last  = last;
    found      = 1'b0;
    idx        = 0;
    for (int i = 0; i < NUM_MASTERS; i++) begin
      idx = i_round_robin ? (int'(last) + 1 + i) % NUM_MASTERS : i;
      if (!found && i_req[idx]) begin
        next_grant[idx] = 1'b1;
        next_last       = `BMX_ID_W'(idx);
        found           = 1'b1;
      end
    end
  end

  // Grant only while the slave can take a new transfer
  assign o_grant = i_en ? next_grant : '0;

  // Remember the winner for fairness
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      last <= `BMX_ID_W'(NUM_MASTERS - 1);
    end else if (i_en && found) begin
      last <= next_last;
    end
  end
endmodule // bmx_slave_arbiter
`default_nettype wire

// ==== design/bmx_matrix.sv ====
// Six master by six slave bus matrix with per master decode and per slave arbitration
`timescale 1ns/1ps
`default_nettype none
`include "bmx_consts.svh"

// Function
// - Six masters run transfers concurrently
// - Own decoder per master, one map
// - Own arbiter per slave, policy per slave
// - Masters: DMA, USB, LCD, periph DMA, CPU
// - Slaves: ROM, SRAM, LCD, USB RAM, ext, bridge
// - Unwired master-slave paths are blocked
// - SRAM, external all; ROM not LCD DMA
// - LCD UI and USB RAM: CPU only
// - Peripheral bridge: masters 0, 1, 2 only
// - Byte, half-word and word transfers
module bmx_matrix #(
  parameter int NUM_MASTERS = `BMX_NUM_MASTERS,
  parameter int NUM_SLAVES  = `BMX_NUM_SLAVES
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst,
  input  wire logic [NUM_SLAVES-1:0] i_arb_round_robin,
  input  wire bmx_pkg::bmx_mreq_s    i_mreq [NUM_MASTERS],
  output bmx_pkg::bmx_mrsp_s         o_mrsp [NUM_MASTERS],
  output bmx_pkg::bmx_sreq_s         o_sreq [NUM_SLAVES],
  input  wire bmx_pkg::bmx_srsp_s    i_srsp [NUM_SLAVES],
  output logic [NUM_SLAVES-1:0]      o_slave_busy,
  output logic [NUM_MASTERS-1:0]     o_err_unwired,
  output logic [NUM_MASTERS-1:0]     o_err_unmapped
);
  import bmx_pkg::*;

  // Master handshake: valid and the request fields stand until done is seen.
  // A refused request (unmapped, unwired, bad size or misaligned) is answered
  // one cycle later with an error and never reaches a slave; a good request
  // waits, with no signal, until the arbiter of its slave picks it.
  // The port ignores requests in its own answer cycle, so a request still
  // standing while done is high is not taken a second time.
  // Slave handshake: the request is registered and holds while valid is high,
  // then drops in the cycle after ready is seen. A slave thus sees one idle
  // cycle between two transfers: some bandwidth traded for outputs that all
  // come straight from flops.

  // Master port sequence
  typedef enum logic [2:0] {
    BMX_M_IDLE = 3'b001,
    BMX_M_BUSY = 3'b010,
    BMX_M_RESP = 3'b100
  } bmx_mstate_e;

  // Slave port sequence
  typedef enum logic [1:0] {
    BMX_S_IDLE = 2'b01,
    BMX_S_BUSY = 2'b10
  } bmx_sstate_e;

  // Connectivity, bit s*NUM_MASTERS+m set when master m is wired to slave s
  // Processor ports are left off the bridge: such accesses end in an error
  localparam logic [NUM_SLAVES*NUM_MASTERS-1:0] CONNECT = {`BMX_CONN_PERIPH, `BMX_CONN_EXT_MEM,
                                                           `BMX_CONN_USB_RAM, `BMX_CONN_LCD_UI,
                                                           `BMX_CONN_SRAM, `BMX_CONN_ROM};

  // Port states
  bmx_mstate_e                 mstate [NUM_MASTERS];
  bmx_sstate_e                 sstate [NUM_SLAVES];

  // Per master decode and request checks
  logic [NUM_MASTERS-1:0]      dec_hit;
  logic [`BMX_ID_W-1:0]        dec_slave [NUM_MASTERS];
  logic [NUM_MASTERS-1:0]      wired;
  logic [NUM_MASTERS-1:0]      size_ok;
  logic [NUM_MASTERS-1:0]      pending;
  logic [NUM_MASTERS-1:0]      bad_req;
  logic [NUM_MASTERS-1:0]      cause_unwired;
  logic [NUM_MASTERS-1:0]      cause_unmapped;

  // Per slave arbitration
  logic [NUM_MASTERS-1:0]      arb_req [NUM_SLAVES];
  logic [NUM_MASTERS-1:0]      grant [NUM_SLAVES];

  // Completion gathered per master
  logic [NUM_MASTERS-1:0]      taken;
  logic [NUM_MASTERS-1:0]      finish;
  logic                        fin_err [NUM_MASTERS];
  logic [`BMX_DATA_W-1:0]      fin_rdata [NUM_MASTERS];
  logic [`BMX_ID_W-1:0]        win_id [NUM_SLAVES];

  // Byte lanes of a transfer from its size and low address bits
  // Misaligned transfers never get here; size_ok refuses them first
  function automatic logic [`BMX_STRB_W-1:0] lanes(input logic [1:0] size, input logic [1:0] low);
    logic [`BMX_STRB_W-1:0] strb;
    strb = '0;
    unique case (size)
      BMX_SIZE_BYTE: strb = `BMX_STRB_W'(4'h1 << low);
      BMX_SIZE_HALF: strb = `BMX_STRB_W'(4'h3 << {low[1], 1'b0});
      BMX_SIZE_WORD: strb = 4'hF;
      default:       strb = '0;
    endcase
    return strb;
  endfunction

  // Per master: own decoder and request checks
  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_master_dec
    bmx_addr_decoder #(
      .NUM_SLAVES (NUM_SLAVES)
    ) u_dec (
      .i_addr  (i_mreq[m].addr),
      .o_hit   (dec_hit[m]),
      .o_slave (dec_slave[m])
    );

    // Path allowed only where the table wires it
    assign wired[m] = dec_hit[m] && CONNECT[int'(dec_slave[m]) * NUM_MASTERS + m];

    // Legal size, naturally aligned
    assign size_ok[m] = (i_mreq[m].size == BMX_SIZE_BYTE) ||
                        (i_mreq[m].size == BMX_SIZE_HALF && !i_mreq[m].addr[0]) ||
                        (i_mreq[m].size == BMX_SIZE_WORD && i_mreq[m].addr[1:0] == 2'h0);

    // A new request is only looked at while the port is idle
    assign pending[m] = i_mreq[m].valid && (mstate[m] == BMX_M_IDLE);
    assign bad_req[m] = pending[m] && !(wired[m] && size_ok[m]);

    // Cause of a refusal, registered beside the answer
    assign cause_unwired[m]  = bad_req[m] && dec_hit[m] && !wired[m];
    assign cause_unmapped[m] = bad_req[m] && !dec_hit[m];
  end

  // Arbiter requests: only good, wired requests reach a slave
  always_comb begin
    for (int s = 0; s < NUM_SLAVES; s++) begin
      arb_req[s] = '0;
      for (int m = 0; m < NUM_MASTERS; m++) begin
        arb_req[s][m] = pending[m] && !bad_req[m] && (int'(dec_slave[m]) == s);
      end
    end
  end

  // Per slave: own arbiter, policy chosen per slave
  // Policy pin is read every cycle, so it may change between transfers
  for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slave_arb
    bmx_slave_arbiter #(
      .NUM_MASTERS (NUM_MASTERS)
    ) u_arb (
      .i_ref_clk     (i_ref_clk),
      .i_rst         (i_rst),
      .i_en          (sstate[s] == BMX_S_IDLE),
      .i_round_robin (i_arb_round_robin[s]),
      .i_req         (arb_req[s]),
      .o_grant       (grant[s])
    );
  end

  // Winner index of each slave, from its one-hot grant
  // Grant is one-hot, so the last set bit is the only one
  always_comb begin
    for (int s = 0; s < NUM_SLAVES; s++) begin
      win_id[s] = '0;
      for (int m = 0; m < NUM_MASTERS; m++) begin
        if (grant[s][m]) begin
          win_id[s] = `BMX_ID_W'(m);
        end
      end
    end
  end

  // Gather per master: granted this cycle, or its slave has answered
  // A master waits on one slave at most, so two answers never collide
  always_comb begin
    for (int m = 0; m < NUM_MASTERS; m++) begin
      taken[m]     = 1'b0;
      finish[m]    = 1'b0;
      fin_err[m]   = 1'b0;
      fin_rdata[m] = '0;
      for (int s = 0; s < NUM_SLAVES; s++) begin
        if (grant[s][m]) begin
          taken[m] = 1'b1;
        end
        if (sstate[s] == BMX_S_BUSY && i_srsp[s].ready && int'(o_sreq[s].master) == m) begin
          finish[m]    = 1'b1;
          fin_err[m]   = i_srsp[s].err;
          fin_rdata[m] = i_srsp[s].rdata;
        end
      end
    end
  end

  // Master side state and answers; each master runs on its own, so all six overlap
  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_master_fsm
    // Port sequence: idle, waiting on its slave, one answer cycle
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        mstate[m] <= BMX_M_IDLE;
      end else begin
        unique case (mstate[m])
          BMX_M_IDLE: begin
            if (bad_req[m]) begin
              mstate[m] <= BMX_M_RESP;
            end else if (taken[m]) begin
              mstate[m] <= BMX_M_BUSY;
            end
          end
          BMX_M_BUSY: begin
            if (finish[m]) begin
              mstate[m] <= BMX_M_RESP;
            end
          end
          BMX_M_RESP: mstate[m] <= BMX_M_IDLE;
          default:    mstate[m] <= BMX_M_IDLE;
        endcase
      end
    end

    // Answer pulse; a refused request never touches a slave
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        o_mrsp[m] <= '0;
      end else if (bad_req[m]) begin
        o_mrsp[m].done  <= 1'b1;
        o_mrsp[m].err   <= 1'b1;
        o_mrsp[m].rdata <= '0;
      end else if (mstate[m] == BMX_M_BUSY && finish[m]) begin
        o_mrsp[m].done  <= 1'b1;
        o_mrsp[m].err   <= fin_err[m];
        o_mrsp[m].rdata <= fin_rdata[m];
      end else begin
        o_mrsp[m].done  <= 1'b0;
      end
    end

    // Unwired cause flag, pulses with the error answer
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        o_err_unwired[m] <= 1'b0;
      end else begin
        o_err_unwired[m] <= cause_unwired[m];
      end
    end

    // Unmapped cause flag, pulses with the error answer
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        o_err_unmapped[m] <= 1'b0;
      end else begin
        o_err_unmapped[m] <= cause_unmapped[m];
      end
    end
  end

  // Slave side: latch the winner's request and hold it until the slave answers
  for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slave_fsm
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        sstate[s] <= BMX_S_IDLE;
        o_sreq[s] <= '0;
      end else begin
        unique case (sstate[s])
          BMX_S_IDLE: begin
            // Capture the winner's fields; they hold until ready is seen
            if (|grant[s]) begin
              sstate[s]        <= BMX_S_BUSY;
              o_sreq[s].valid  <= 1'b1;
              o_sreq[s].addr   <= i_mreq[win_id[s]].addr;
              o_sreq[s].write  <= i_mreq[win_id[s]].write;
              o_sreq[s].size   <= i_mreq[win_id[s]].size;
              o_sreq[s].strb   <= lanes(i_mreq[win_id[s]].size, i_mreq[win_id[s]].addr[1:0]);
              o_sreq[s].wdata  <= i_mreq[win_id[s]].wdata;
              o_sreq[s].master <= win_id[s];
            end
          end
          BMX_S_BUSY: begin
            // Ready is taken from the first cycle valid is high, so a slave may answer in the cycle valid rises
            if (i_srsp[s].ready) begin
              sstate[s]       <= BMX_S_IDLE;
              o_sreq[s].valid <= 1'b0;
            end
          end
          default: begin
            sstate[s]       <= BMX_S_IDLE;
            o_sreq[s].valid <= 1'b0;
          end
        endcase
      end
    end

    // Busy flag from the port state, kept apart so valid can be held against it
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        o_slave_busy[s] <= 1'b0;
      end else if (sstate[s] == BMX_S_IDLE) begin
        o_slave_busy[s] <= |grant[s];
      end else if (sstate[s] != BMX_S_BUSY || i_srsp[s].ready) begin
        o_slave_busy[s] <= 1'b0;
      end
    end
  end

  // Slave indices follow the window order of the decoder table, and the
  // matrix never renumbers them: request port s always leads to slave s

endmodule // bmx_matrix
`default_nettype wire

// ==== tb/bmx_slave_model.sv ====
// Memory slave model standing at one slave port of the bus matrix
`timescale 1ns/1ps
`default_nettype none
module bmx_slave_model #(
  parameter int WAIT = 0
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire bmx_pkg::bmx_sreq_s i_sreq,
  output bmx_pkg::bmx_srsp_s      o_srsp
);
  import bmx_pkg::*;
  logic [31:0] mem [16];
  int          cnt;

  // Ready only while a request stands; idle data toggles so stale reads show
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt    <= 0;
      o_srsp <= '0;
      for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
    end else if (i_sreq.valid && !o_srsp.ready && cnt >= WAIT) begin
      cnt          <= 0;
      o_srsp.ready <= 1'b1;
      o_srsp.rdata <= mem[i_sreq.addr[5:2]];
      for (int b = 0; b < 4; b++) begin
        if (i_sreq.write && i_sreq.strb[b]) mem[i_sreq.addr[5:2]][8*b +: 8] <= i_sreq.wdata[8*b +: 8];
      end
    end else begin
      cnt          <= i_sreq.valid ? cnt + 1 : 0;
      o_srsp.ready <= 1'b0;
      o_srsp.rdata <= ~o_srsp.rdata;
    end
  end
endmodule // bmx_slave_model
`default_nettype wire

// ==== tb/bmx_matrix_chk.sv ====
// Port checker of the bus matrix, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module bmx_matrix_chk #(
  parameter int NUM_MASTERS = 6,
  parameter int NUM_SLAVES  = 6
) (
  input wire logic                   i_ref_clk,
  input wire logic                   i_rst,
  input wire logic [NUM_SLAVES-1:0]  i_arb_round_robin,
  input wire bmx_pkg::bmx_mreq_s     i_mreq [NUM_MASTERS],
  input wire bmx_pkg::bmx_mrsp_s     o_mrsp [NUM_MASTERS],
  input wire bmx_pkg::bmx_sreq_s     o_sreq [NUM_SLAVES],
  input wire bmx_pkg::bmx_srsp_s     i_srsp [NUM_SLAVES],
  input wire logic [NUM_SLAVES-1:0]  o_slave_busy,
  input wire logic [NUM_MASTERS-1:0] o_err_unwired,
  input wire logic [NUM_MASTERS-1:0] o_err_unmapped
);
  import bmx_pkg::*;
  // Own copy of map and wiring, so a slip in the shared constants shows
  localparam logic [31:0] LO [6] = '{32'h0040_0000, 32'h0030_0000, 32'h0050_0000,
                                     32'h0060_0000, 32'h1000_0000, 32'hF000_0000};
  localparam logic [31:0] HI [6] = '{32'h004F_FFFF, 32'h003F_FFFF, 32'h005F_FFFF,
                                     32'h006F_FFFF, 32'h8FFF_FFFF, 32'hFFFF_FFFF};
  localparam logic [5:0]  WIRED [6] = '{6'h3B, 6'h3F, 6'h30, 6'h30, 6'h3F, 6'h07};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // Address lies in some slave window
  function automatic logic mapped(input logic [31:0] a);
    mapped = 1'b0;
    for (int s = 0; s < 6; s++) mapped = mapped | (a inside {[LO[s]:HI[s]]});
  endfunction

  // Byte lanes of a transfer of this size and offset
  function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
    lanes = (sz == 2'h0) ? (4'h1 << a) : (sz == 2'h1) ? (4'h3 << {a[1], 1'b0}) : 4'hF;
  endfunction

  // Slave side
  for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slv
    AST_BUSY_IS_VALID: assert property (o_slave_busy[s] == o_sreq[s].valid)
      else $error("busy differs from valid");
    AST_REQ_HOLDS: assert property (o_sreq[s].valid && !i_srsp[s].ready
      |=> o_sreq[s].valid && $stable(o_sreq[s])) else $error("request moved before ready");
    AST_REQ_DROPS: assert property (o_sreq[s].valid && i_srsp[s].ready |=> !o_sreq[s].valid)
      else $error("request stayed after ready");
    AST_IN_WINDOW: assert property (o_sreq[s].valid |-> o_sreq[s].addr inside {[LO[s]:HI[s]]})
      else $error("address outside slave window");
    AST_WIRED_ONLY: assert property (o_sreq[s].valid |-> WIRED[s][o_sreq[s].master])
      else $error("unwired master reached slave");
    AST_LANES: assert property (o_sreq[s].valid
      |-> o_sreq[s].strb == lanes(o_sreq[s].size, o_sreq[s].addr[1:0])) else $error("wrong byte lanes");
    AST_OWNER: assert property (o_sreq[s].valid
      |-> i_mreq[o_sreq[s].master].addr == o_sreq[s].addr) else $error("master id does not own request");
  end

  // Master side
  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_mst
    AST_UNWIRED_ANSWER: assert property (o_err_unwired[m] |-> o_mrsp[m].done && o_mrsp[m].err)
      else $error("unwired flag without error answer");
    AST_UNMAPPED_ANSWER: assert property (o_err_unmapped[m]
      |-> o_mrsp[m].done && o_mrsp[m].err && !o_err_unwired[m]) else $error("unmapped flag without error");
    AST_DONE_PULSE: assert property (o_mrsp[m].done |=> !o_mrsp[m].done)
      else $error("done longer than one cycle");
    AST_UNMAPPED_FAST: assert property ($rose(i_mreq[m].valid) && !mapped(i_mreq[m].addr)
      |=> o_mrsp[m].done && o_err_unmapped[m]) else $error("unmapped request not answered next cycle");
  end

  COV_UNWIRED: cover property (o_err_unwired != '0);
  COV_UNMAPPED: cover property (o_err_unmapped != '0);
  COV_PARALLEL: cover property (&o_slave_busy[4:0]);
endmodule // bmx_matrix_chk

bind bmx_matrix bmx_matrix_chk #(.NUM_MASTERS(NUM_MASTERS), .NUM_SLAVES(NUM_SLAVES)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_arb_round_robin(i_arb_round_robin),
  .i_mreq(i_mreq), .o_mrsp(o_mrsp), .o_sreq(o_sreq), .i_srsp(i_srsp), .o_slave_busy(o_slave_busy),
  .o_err_unwired(o_err_unwired), .o_err_unmapped(o_err_unmapped));
`default_nettype wire

// ==== tb/bmx_matrix_tb.sv ====
// Self-checking bench of the bus matrix with six memory slave models
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %h got %h", nm, e, g); end end
module bmx_matrix_tb;
  import bmx_pkg::*;
  typedef struct packed {
    logic [31:0] addr;
    logic [5:0]  wired;
    logic        unmapped;
  } bmx_row_s;

  logic        clk;
  logic        rst;
  logic [5:0]  rr;
  logic [5:0]  busy;
  logic [5:0]  uw;
  logic [5:0]  um;
  bmx_mreq_s   mreq [6];
  bmx_mrsp_s   mrsp [6];
  bmx_sreq_s   sreq [6];
  bmx_srsp_s   srsp [6];
  logic [34:0] res [6];
  realtime     t_done [6];
  realtime     t0;
  int          error_cnt = 0;
  int          n_compared = 0;
  logic        ok;
  logic [31:0] d;
  // Window edges with the masters wired to them, then unmapped holes
  bmx_row_s    rows [10] = '{
    '{32'h0040_0000, 6'h3B, 1'b0}, '{32'h003F_FFFC, 6'h3F, 1'b0}, '{32'h0050_0000, 6'h30, 1'b0},
    '{32'h006F_FFFC, 6'h30, 1'b0}, '{32'h8FFF_FFFC, 6'h3F, 1'b0}, '{32'hF000_0000, 6'h07, 1'b0},
    '{32'h0000_0000, 6'h00, 1'b1}, '{32'h002F_FFFC, 6'h00, 1'b1}, '{32'h0070_0000, 6'h00, 1'b1},
    '{32'h9000_0000, 6'h00, 1'b1}};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  bmx_matrix dut (
    .i_ref_clk(clk), .i_rst(rst), .i_arb_round_robin(rr), .i_mreq(mreq), .o_mrsp(mrsp),
    .o_sreq(sreq), .i_srsp(srsp), .o_slave_busy(busy), .o_err_unwired(uw), .o_err_unmapped(um));

  // Slaves answer one to three cycles after valid rises, so stalls differ per slave
  for (genvar s = 0; s < 6; s++) begin : g_slv
    bmx_slave_model #(.WAIT(s % 3)) u_slv (.i_ref_clk(clk), .i_rst(rst), .i_sreq(sreq[s]), .o_srsp(srsp[s]));
  end

  // One single-beat transfer, request held from a falling edge until done
  task automatic xfer(input int m, input logic [31:0] a, input logic w, input logic [1:0] sz,
                      input logic [31:0] wd);
    int n;
    n = 0;
    @(negedge clk);
    mreq[m] = '{1'b1, a, w, sz, wd};
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (mrsp[m].done !== 1'b1 && n < 40);
    res[m] = {mrsp[m].err, uw[m], um[m], mrsp[m].rdata};
    t_done[m] = $realtime;
    `CHK("done_wait", 1'b1, mrsp[m].done)
    @(negedge clk);
    mreq[m].valid = 1'b0;
  endtask

  task automatic test_done();
    $display("Counts: %0d compared, %0d mismatched", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    rr  = 6'h00;
    for (int m = 0; m < 6; m++) mreq[m] = '0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    // Quiet outputs after reset
    `CHK("idle", 19'h0, {busy, uw, um, mrsp[0].done})
    $display("Test reset done");
    // Every master against every row: write a word, read it back
    foreach (rows[i]) begin
      for (int m = 0; m < 6; m++) begin
        ok = rows[i].wired[m];
        d  = {rows[i].addr[31:20], 12'hA5C, 4'(i), 4'(m)};
        xfer(m, rows[i].addr, 1'b1, BMX_SIZE_WORD, d);
        `CHK("wr_flags", {~ok, ~ok & ~rows[i].unmapped, rows[i].unmapped}, res[m][34:32])
        xfer(m, rows[i].addr, 1'b0, BMX_SIZE_WORD, 32'h0);
        `CHK("rd_flags", {~ok, ~ok & ~rows[i].unmapped, rows[i].unmapped}, res[m][34:32])
        if (ok) `CHK("rd_data", d, res[m][31:0])
      end
    end
    $display("Test map done");
    // Byte and half-word lanes merge into one word; odd sizes refused
    xfer(5, 32'h0030_0010, 1'b1, BMX_SIZE_WORD, 32'h1122_3344);
    xfer(5, 32'h0030_0011, 1'b1, BMX_SIZE_BYTE, 32'hAAAA_AAAA);
    xfer(5, 32'h0030_0012, 1'b1, BMX_SIZE_HALF, 32'hBBBB_BBBB);
    xfer(5, 32'h0030_0010, 1'b0, BMX_SIZE_WORD, 32'h0);
    `CHK("lanes", {3'h0, 32'hBBBB_AA44}, res[5])
    xfer(4, 32'h0030_0011, 1'b0, BMX_SIZE_HALF, 32'h0);
    `CHK("misaligned", 3'h4, res[4][34:32])
    xfer(3, 32'h0030_0010, 1'b0, 2'h3, 32'h0);
    `CHK("size3", 3'h4, res[3][34:32])
    $display("Test sizes done");
    // Five masters on five slaves at once: one transfer time, not five
    t0 = $realtime;
    fork
      xfer(0, 32'h0040_0000, 1'b0, BMX_SIZE_WORD, 32'h0);
      xfer(1, 32'h0030_0000, 1'b0, BMX_SIZE_WORD, 32'h0);
      xfer(2, 32'h1000_0000, 1'b0, BMX_SIZE_WORD, 32'h0);
      xfer(4, 32'h0050_0000, 1'b0, BMX_SIZE_WORD, 32'h0);
      xfer(5, 32'h0060_0000, 1'b0, BMX_SIZE_WORD, 32'h0);
    join
    `CHK("parallel", 1'b1, ($realtime - t0) < 1200.0)
    $display("Test parallel done");
    // SRAM contention: fixed priority, then round robin after master 1 won
    for (int k = 0; k < 2; k++) begin
      if (k == 1) xfer(1, 32'h0030_0020, 1'b0, BMX_SIZE_WORD, 32'h0);
      fork
        xfer(1, 32'h0030_0020, 1'b0, BMX_SIZE_WORD, 32'h0);
        xfer(3, 32'h0030_0024, 1'b0, BMX_SIZE_WORD, 32'h0);
      join
      `CHK("arb_order", k == 0, t_done[1] < t_done[3])
      @(negedge clk);
      rr[1] = 1'b1;
    end
    $display("Test arbitration done");
    // Reset in mid transfer: outputs quiet again, next transfer clean
    @(negedge clk);
    mreq[0] = '{1'b1, 32'h0040_0008, 1'b0, BMX_SIZE_WORD, 32'h0};
    @(negedge clk);
    rst     = 1'b1;
    mreq[0] = '0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK("reset_mid", 19'h0, {busy, uw, um, mrsp[0].done})
    xfer(0, 32'h0040_0008, 1'b0, BMX_SIZE_WORD, 32'h0);
    `CHK("after_reset", 3'h0, res[0][34:32])
    $display("Test mid reset done");
    test_done();
  end

  // Watchdog far beyond the roughly 450 cycles the tests take
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("Error watchdog exp finish got hang");
    test_done();
  end
endmodule // bmx_matrix_tb
`default_nettype wire
